// ==== design/event_pin_pkg.sv ====
// Shared constants and types for the thermal event pin monitor
package event_pin_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFS_STATUS_TWO = 8'h42;
    localparam logic [7:0] OFS_REMOTE_ONE_CFG = 8'h5f;
    localparam logic [7:0] OFS_LOCAL_CFG = 8'h60;
    localparam logic [7:0] OFS_REMOTE_TWO_CFG = 8'h61;
    localparam logic [7:0] OFS_REMOTE_ONE_CRIT = 8'h6a;
    localparam logic [7:0] OFS_LOCAL_CRIT = 8'h6b;
    localparam logic [7:0] OFS_REMOTE_TWO_CRIT = 8'h6c;
    localparam logic [7:0] OFS_MASK_TWO = 8'h75;
    localparam logic [7:0] OFS_CONFIG_THREE = 8'h78;
    localparam logic [7:0] OFS_TIMER = 8'h79;
    localparam logic [7:0] OFS_TIME_LIMIT = 8'h7a;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_EVENT_PIN_ENABLE = 1;
    localparam int BIT_FULL_SPEED_ON_EVENT = 2;
    localparam int BIT_CHAN_OUT_ENABLE = 3;
    localparam int BIT_EVENT_LIMIT = 5;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0] RST_CHAN_CFG = 8'h00;
    localparam logic [7:0] RST_CRIT_LIMIT = 8'h64;
    localparam logic [7:0] RST_MASK_TWO = 8'h00;
    localparam logic [7:0] RST_CONFIG_THREE = 8'h00;
    localparam logic [7:0] RST_TIME_LIMIT = 8'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam longint TICK_TIME_PS = 64'd22760000000;
    localparam int TICK_CYCLES = int'(TICK_TIME_PS / CLK_PERIOD_PS);
    localparam logic [7:0] TIMER_FULL = 8'hff;
    localparam logic [7:0] FAN_FULL_DUTY = 8'hff;
    localparam logic [7:0] FAN_OFF_DUTY = 8'h00;
    localparam int CHANNELS = 3;
    localparam int FANS = 3;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic [1:0] channel;
        logic [9:0] temp;
    } measure_t;

    typedef struct packed {
        logic [2:0] auto_mode;
        logic [2:0] above_start;
        logic [2:0][7:0] duty;
    } fan_setting_t;

    typedef struct packed {
        logic sync_first;
        logic sync_second;
        logic [2:0][7:0] chan_cfg;
        logic [2:0][7:0] crit_limit;
        logic [7:0] mask_two;
        logic [7:0] config_three;
        logic [7:0] time_limit;
        logic seen;
        logic [7:0] ticks;
        logic [31:0] sub_count;
        logic event_limit_flag;
        logic [2:0] chan_hot;
        logic pin_drive;
        logic alert_req;
        logic [2:0][7:0] fan_duty;
        logic [7:0] rdata;
    } state_t;

endpackage

// ==== design/thermal_event_pin_monitor.sv ====
// Thermal event pin monitor: assertion timer, limit flag, fan full_speed_on_event, pin drive
//
// Summary of operation
// - Pin function only when enable bit set
// - Full_speed_on_event bit forces fans full while pin low
// - Full_speed_on_event only affects fans already running
// - Full_speed_on_event clear leaves fans at programmed duty
// - Timer accumulates while pin asserted, pauses otherwise
// - Timer clears on read, saturates at full
// - Bit0 on first assertion, then 22.76 ms counts
// - Read during assertion restarts at one
// - Read during assertion, zero limit sets flag again
// - Timer above limit sets flag, requests alert
// - Limit spans first assertion to 5.804 s
// - Limit zero first assertion; one above 45.52 ms
// - Mask bit suppresses alert, flag still set
// - Drive pin low while channel above critical
// - Channel hot state re-evaluated only per channel measurement; enable bit writes change output at once
// - One critical limit register per channel, three in all
// - Per-channel enable bits gate pin output
// - Flag sticky until cause gone and read
`timescale 1ns/10ps

module thermal_event_pin_monitor #(
    parameter int TICK_CYCLES = event_pin_pkg::TICK_CYCLES
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic EVENT_PIN_IN,
    output logic EVENT_PIN_OUT,
    output logic EVENT_PIN_OE_N,
    input wire logic MEAS_VALID,
    input wire event_pin_pkg::measure_t MEAS,
    input wire event_pin_pkg::fan_setting_t FAN_SET,
    output logic [2:0][7:0] FAN_DUTY,
    output logic EVENT_LIMIT_FLAG,
    output logic ALERT_REQ
);

    event_pin_pkg::state_t s_q;
    event_pin_pkg::state_t s_d;

    // Temperature carries two fraction bits, so a strict compare against
    // the limit scaled by four means at least a quarter degree above it.
    function automatic logic above_limit(input logic [9:0] temp, input logic [7:0] lim);
        above_limit = temp > {lim, 2'b00};
    endfunction

    // Shown timer value: one after the first assertion until two ticks pass
    function automatic logic [7:0] shown_timer(input logic seen, input logic [7:0] ticks);
        if (ticks >= 8'h02) begin
            shown_timer = ticks;
        end else begin
            shown_timer = {7'h00, seen};
        end
    endfunction

    logic pin_asserted;
    logic timer_read;
    logic status_read;
    logic [7:0] timer_now;
    logic limit_cond;
    logic fan_running;
    logic full_speed_on_event;

    always_comb begin
        s_d = s_q;
        pin_asserted = 1'b0;
        timer_read = 1'b0;
        status_read = 1'b0;
        timer_now = 8'h00;
        limit_cond = 1'b0;
        fan_running = 1'b0;
        full_speed_on_event = 1'b0;

        // ************************************************************
        // Pin input
        // ************************************************************
        s_d.sync_first = EVENT_PIN_IN;
        s_d.sync_second = s_q.sync_first;
        pin_asserted = !s_q.sync_second
            && s_q.config_three[event_pin_pkg::BIT_EVENT_PIN_ENABLE];

        timer_read = RD && (ADDR == event_pin_pkg::OFS_TIMER);
        status_read = RD && (ADDR == event_pin_pkg::OFS_STATUS_TWO);

        // ************************************************************
        // Register writes
        // ************************************************************
        if (WR) begin
            case (ADDR)
                event_pin_pkg::OFS_REMOTE_ONE_CFG: s_d.chan_cfg[0] = WDATA;
                event_pin_pkg::OFS_LOCAL_CFG: s_d.chan_cfg[1] = WDATA;
                event_pin_pkg::OFS_REMOTE_TWO_CFG: s_d.chan_cfg[2] = WDATA;
                event_pin_pkg::OFS_REMOTE_ONE_CRIT: s_d.crit_limit[0] = WDATA;
                event_pin_pkg::OFS_LOCAL_CRIT: s_d.crit_limit[1] = WDATA;
                event_pin_pkg::OFS_REMOTE_TWO_CRIT: s_d.crit_limit[2] = WDATA;
                event_pin_pkg::OFS_MASK_TWO: s_d.mask_two = WDATA;
                event_pin_pkg::OFS_CONFIG_THREE: s_d.config_three = WDATA;
                event_pin_pkg::OFS_TIME_LIMIT: s_d.time_limit = WDATA;
                default: ;
            endcase
        end

        // ************************************************************
        // Assertion timer
        // ************************************************************
        if (timer_read) begin
            // Cleared on read; an ongoing assertion shows up as one at once
            s_d.ticks = 8'h00;
            s_d.sub_count = 32'h0;
            s_d.seen = pin_asserted;
        end else if (pin_asserted) begin
            s_d.seen = 1'b1;
            if (s_q.ticks != event_pin_pkg::TIMER_FULL) begin
                if (s_q.sub_count == 32'(TICK_CYCLES - 1)) begin
                    s_d.sub_count = 32'h0;
                    s_d.ticks = s_q.ticks + 8'h01;
                end else begin
                    s_d.sub_count = s_q.sub_count + 32'h1;
                end
            end
        end
        // Saturated timer holds without counting until it is read

        timer_now = shown_timer(s_q.seen, s_q.ticks);
        limit_cond = timer_now > s_q.time_limit;

        // ************************************************************
        // Sticky limit flag and alert request
        // ************************************************************
        // Read during assertion with a zero limit reports at once again
        if (timer_read && pin_asserted && s_q.time_limit == 8'h00) begin
            s_d.event_limit_flag = 1'b1;
        end else if (limit_cond) begin
            s_d.event_limit_flag = 1'b1;
        end else if (status_read) begin
            s_d.event_limit_flag = 1'b0;
        end
        // Alert follows the flag unless the mask bit is set, so it stays active until the flag clears or is masked
        s_d.alert_req = s_d.event_limit_flag
            && !s_q.mask_two[event_pin_pkg::BIT_EVENT_LIMIT];

        // ************************************************************
        // Pin output
        // ************************************************************
        // Hot state changes only when that channel is measured again
        if (MEAS_VALID && MEAS.channel < 2'd3) begin
            s_d.chan_hot[MEAS.channel] =
                above_limit(MEAS.temp, s_q.crit_limit[MEAS.channel]);
        end
        s_d.pin_drive = 1'b0;
        for (int c = 0; c < event_pin_pkg::CHANNELS; c++) begin
            if (s_q.chan_hot[c] && s_q.chan_cfg[c][event_pin_pkg::BIT_CHAN_OUT_ENABLE]) begin
                s_d.pin_drive = 1'b1;
            end
        end
        s_d.pin_drive = s_d.pin_drive
            && s_q.config_three[event_pin_pkg::BIT_EVENT_PIN_ENABLE];

        // ************************************************************
        // Fan full_speed_on_event
        // ************************************************************
        // Own drive also pulls the pin low and so boosts the fans as well;
        // the pin level cannot tell the two drivers apart.
        full_speed_on_event = pin_asserted
            && s_q.config_three[event_pin_pkg::BIT_FULL_SPEED_ON_EVENT];
        for (int f = 0; f < event_pin_pkg::FANS; f++) begin
            if (FAN_SET.auto_mode[f]) begin
                fan_running = FAN_SET.above_start[f];
            end else begin
                fan_running = FAN_SET.duty[f] != event_pin_pkg::FAN_OFF_DUTY;
            end
            if (full_speed_on_event && fan_running) begin
                s_d.fan_duty[f] = event_pin_pkg::FAN_FULL_DUTY;
            end else begin
                s_d.fan_duty[f] = FAN_SET.duty[f];
            end
        end

        // ************************************************************
        // Register reads
        // ************************************************************
        s_d.rdata = 8'h00;
        if (RD) begin
            case (ADDR)
                event_pin_pkg::OFS_STATUS_TWO:
                    s_d.rdata[event_pin_pkg::BIT_EVENT_LIMIT] = s_q.event_limit_flag;
                event_pin_pkg::OFS_REMOTE_ONE_CFG: s_d.rdata = s_q.chan_cfg[0];
                event_pin_pkg::OFS_LOCAL_CFG: s_d.rdata = s_q.chan_cfg[1];
                event_pin_pkg::OFS_REMOTE_TWO_CFG: s_d.rdata = s_q.chan_cfg[2];
                event_pin_pkg::OFS_REMOTE_ONE_CRIT: s_d.rdata = s_q.crit_limit[0];
                event_pin_pkg::OFS_LOCAL_CRIT: s_d.rdata = s_q.crit_limit[1];
                event_pin_pkg::OFS_REMOTE_TWO_CRIT: s_d.rdata = s_q.crit_limit[2];
                event_pin_pkg::OFS_MASK_TWO: s_d.rdata = s_q.mask_two;
                event_pin_pkg::OFS_CONFIG_THREE: s_d.rdata = s_q.config_three;
                event_pin_pkg::OFS_TIMER: s_d.rdata = timer_now;
                event_pin_pkg::OFS_TIME_LIMIT: s_d.rdata = s_q.time_limit;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s_q <= '0;
            s_q.sync_first <= 1'b1;
            s_q.sync_second <= 1'b1;
            s_q.chan_cfg <= {3{event_pin_pkg::RST_CHAN_CFG}};
            s_q.crit_limit <= {3{event_pin_pkg::RST_CRIT_LIMIT}};
            s_q.mask_two <= event_pin_pkg::RST_MASK_TWO;
            s_q.config_three <= event_pin_pkg::RST_CONFIG_THREE;
            s_q.time_limit <= event_pin_pkg::RST_TIME_LIMIT;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA = s_q.rdata;
    assign EVENT_PIN_OUT = 1'b0;
    assign EVENT_PIN_OE_N = !s_q.pin_drive;
    assign FAN_DUTY = s_q.fan_duty;
    assign EVENT_LIMIT_FLAG = s_q.event_limit_flag;
    assign ALERT_REQ = s_q.alert_req;

endmodule // thermal_event_pin_monitor

// ==== sim/thermal_event_pin_checker_assertions.sv ====
// Port checker for the thermal event pin monitor
`timescale 1ns/10ps

module thermal_event_pin_checker #(
    parameter int TICK_CYCLES = 8
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic EVENT_PIN_IN,
    input wire logic EVENT_PIN_OUT,
    input wire logic EVENT_PIN_OE_N,
    input wire logic MEAS_VALID,
    input wire event_pin_pkg::fan_setting_t FAN_SET,
    input wire logic [2:0][7:0] FAN_DUTY,
    input wire logic EVENT_LIMIT_FLAG,
    input wire logic ALERT_REQ
);
    // ************************************************************
    // Port relations
    // ************************************************************
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);

    chk_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not zero outside a reply");
    // Alert and flag are registered from the same next value, so alert is never high without the flag
    chk_alert_cause: assert property (ALERT_REQ |-> EVENT_LIMIT_FLAG)
        else $error("alert without limit flag");
    chk_flag_clear_read: assert property ($fell(EVENT_LIMIT_FLAG) |->
        $past(RD) && $past(ADDR) == event_pin_pkg::OFS_STATUS_TWO)
        else $error("limit flag dropped without status read");
    chk_pin_drive_low: assert property (EVENT_PIN_OUT == 1'b0)
        else $error("pin driven high");
    // Drive may only move after a measurement or a register write
    chk_drive_cause: assert property ($changed(EVENT_PIN_OE_N) |->
        $past(MEAS_VALID, 2) || $past(WR, 2))
        else $error("pin drive changed without measurement");
    chk_no_full_speed_on_event_idle: assert property ((!RST && EVENT_PIN_IN) [*4] |->
        FAN_DUTY == $past(FAN_SET.duty))
        else $error("fan duty altered while pin released");
    chk_off_fan_stays: assert property (!FAN_SET.auto_mode[1] && FAN_SET.duty[1] == 8'h00
        |=> FAN_DUTY[1] == 8'h00)
        else $error("stopped fan boosted");
    chk_auto_below: assert property (FAN_SET.auto_mode[2] && !FAN_SET.above_start[2]
        |=> FAN_DUTY[2] == $past(FAN_SET.duty[2]))
        else $error("fan below start boosted");

    cover property ($rose(EVENT_LIMIT_FLAG));
    cover property ($fell(EVENT_PIN_OE_N));
    cover property (FAN_DUTY[0] == 8'hff);
endmodule // thermal_event_pin_checker

bind thermal_event_pin_monitor thermal_event_pin_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_inst (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
    .EVENT_PIN_IN(EVENT_PIN_IN), .EVENT_PIN_OUT(EVENT_PIN_OUT),
    .EVENT_PIN_OE_N(EVENT_PIN_OE_N), .MEAS_VALID(MEAS_VALID), .FAN_SET(FAN_SET),
    .FAN_DUTY(FAN_DUTY), .EVENT_LIMIT_FLAG(EVENT_LIMIT_FLAG), .ALERT_REQ(ALERT_REQ));

// ==== sim/thermal_event_pin_monitor_bench.sv ====
// Self-checking bench for the thermal event pin monitor
`timescale 1ns/10ps

module thermal_event_pin_monitor_bench;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic MEAS_VALID = 1'b0;
    logic [7:0] ADDR = 8'h00;
    logic [7:0] WDATA = 8'h00;
    event_pin_pkg::measure_t MEAS = '0;
    event_pin_pkg::fan_setting_t FAN_SET = '0;
    logic [7:0] RDATA;
    logic [2:0][7:0] FAN_DUTY;
    logic EVENT_PIN_OUT, EVENT_PIN_OE_N, EVENT_LIMIT_FLAG, ALERT_REQ, pull_low, pin;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] ofs [10] = '{8'h5f, 8'h60, 8'h61, 8'h6a, 8'h6b, 8'h6c, 8'h75, 8'h78, 8'h79, 8'h7a};
    logic [7:0] rstv [10] = '{8'h00, 8'h00, 8'h00, 8'h64, 8'h64, 8'h64, 8'h00, 8'h00, 8'h00, 8'h00};

    // Pulled-up wire: released by both parties it reads high
    assign pin = (EVENT_PIN_OE_N | EVENT_PIN_OUT) & ~pull_low;

    thermal_event_pin_monitor #(.TICK_CYCLES(8)) thermal_event_pin_monitor_inst (
        .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .EVENT_PIN_IN(pin), .EVENT_PIN_OUT(EVENT_PIN_OUT), .EVENT_PIN_OE_N(EVENT_PIN_OE_N),
        .MEAS_VALID(MEAS_VALID), .MEAS(MEAS), .FAN_SET(FAN_SET), .FAN_DUTY(FAN_DUTY),
        .EVENT_LIMIT_FLAG(EVENT_LIMIT_FLAG), .ALERT_REQ(ALERT_REQ));
    thermal_source_model thermal_source_model_inst (.CLK(CLK), .pull_low(pull_low));

    always #2.5 CLK = ~CLK;
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // ************************************************************
    // Bus, pin and check helpers
    // ************************************************************
    task automatic cmp(input string n, input logic [23:0] e, input logic [23:0] s);
        checks_done++;
        if (s !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        cmp("rdata", 24'(e), 24'(RDATA));
    endtask
    task automatic pull(input int n);
        thermal_source_model_inst.hold(n);
    endtask
    task automatic meas(input logic [1:0] ch, input logic [9:0] t);
        @(posedge CLK);
        MEAS_VALID <= 1'b1;
        MEAS <= '{ch, t};
        @(posedge CLK);
        MEAS_VALID <= 1'b0;
    endtask
    task automatic reset_dut;
        @(posedge CLK);
        RST <= 1'b1;
        repeat (12) @(posedge CLK);
        RST <= 1'b0;
    endtask

    task automatic regs_scenario;
        for (int i = 0; i < 10; i++) rc(ofs[i], rstv[i]);
        rc(8'h00, 8'h00);
        for (int i = 0; i < 10; i++) wr(ofs[i], 8'h5a);
        for (int i = 0; i < 10; i++) rc(ofs[i], (ofs[i] == 8'h79) ? 8'h00 : 8'h5a);
        reset_dut();
    endtask
    task automatic timer_scenario;
        pull(20);
        idle(4);
        rc(8'h79, 8'h00);
        wr(8'h78, 8'h02);
        pull(4);
        idle(4);
        rc(8'h79, 8'h01);
        rc(8'h79, 8'h00);
        pull(13);
        idle(3);
        pull(13);
        idle(4);
        rc(8'h79, 8'h03);
        pull(2200);
        idle(4);
        rc(8'h79, 8'hff);
        rc(8'h79, 8'h00);
    endtask
    task automatic read_during_scenario;
        rd(8'h42);
        cmp("flag", 24'h0, 24'(EVENT_LIMIT_FLAG));
        fork
            pull(30);
            begin
                idle(10);
                cmp("alert", 24'h1, 24'(ALERT_REQ));
                rd(8'h79);
                rc(8'h79, 8'h01);
                cmp("flag", 24'h1, 24'(EVENT_LIMIT_FLAG));
            end
        join
        idle(4);
        rd(8'h79);
        cmp("flag", 24'h1, 24'(EVENT_LIMIT_FLAG));
        rc(8'h42, 8'h20);
        cmp("flag", 24'h0, 24'(EVENT_LIMIT_FLAG));
        idle(1);
        cmp("alert", 24'h0, 24'(ALERT_REQ));
    endtask
    task automatic limit_scenario;
        wr(8'h7a, 8'h01);
        wr(8'h75, 8'h20);
        pull(6);
        idle(4);
        cmp("flag", 24'h0, 24'(EVENT_LIMIT_FLAG));
        pull(14);
        idle(4);
        cmp("flag", 24'h1, 24'(EVENT_LIMIT_FLAG));
        cmp("alert", 24'h0, 24'(ALERT_REQ));
        wr(8'h75, 8'h00);
        idle(2);
        cmp("alert", 24'h1, 24'(ALERT_REQ));
        rd(8'h79);
        rd(8'h42);
        wr(8'h7a, 8'h00);
    endtask
    task automatic full_speed_on_event_scenario;
        @(posedge CLK);
        FAN_SET <= '{3'b100, 3'b000, {8'h30, 8'h00, 8'h40}};
        fork
            pull(12);
            begin
                idle(6);
                cmp("fan duty", {8'h30, 8'h00, 8'h40}, FAN_DUTY);
            end
        join
        wr(8'h78, 8'h06);
        fork
            pull(16);
            begin
                idle(6);
                cmp("fan duty", {8'h30, 8'h00, 8'hff}, FAN_DUTY);
                @(posedge CLK);
                FAN_SET.above_start <= 3'b100;
                idle(2);
                cmp("fan duty", {8'hff, 8'h00, 8'hff}, FAN_DUTY);
            end
        join
        idle(4);
        cmp("fan duty", {8'h30, 8'h00, 8'h40}, FAN_DUTY);
        wr(8'h78, 8'h02);
    endtask
    task automatic drive_scenario;
        wr(8'h60, 8'h08);
        wr(8'h6b, 8'h50);
        meas(2'd1, 10'd320);
        meas(2'd2, 10'd1000);
        idle(4);
        cmp("drive", 24'h1, 24'(EVENT_PIN_OE_N));
        meas(2'd1, 10'd321);
        idle(3);
        cmp("drive", 24'h0, 24'(EVENT_PIN_OE_N));
        idle(20);
        cmp("drive", 24'h0, 24'(EVENT_PIN_OE_N));
        meas(2'd1, 10'd320);
        idle(3);
        cmp("drive", 24'h1, 24'(EVENT_PIN_OE_N));
    endtask

    task automatic tally_and_finish;
        if (err_total == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        reset_dut();
        regs_scenario();
        timer_scenario();
        read_during_scenario();
        limit_scenario();
        full_speed_on_event_scenario();
        drive_scenario();
        tally_and_finish();
    end
endmodule // thermal_event_pin_monitor_bench

// ==== sim/thermal_source_model.sv ====
// Outside thermal source that pulls the event pin low
`timescale 1ns/10ps

module thermal_source_model (
    input wire logic CLK,
    output logic pull_low
);
    initial pull_low = 1'b0;

    // Open-drain only: never drives high, so the device can share the wire
    task automatic hold(input int cycles);
        @(posedge CLK);
        pull_low <= 1'b1;
        repeat (cycles) @(posedge CLK);
        pull_low <= 1'b0;
    endtask
endmodule // thermal_source_model
